// ### rtl/afs_pkg.sv
// constants and types shared by the serial port and the ready strobe logic
// assumes one core clock at 100 MHz that also stands for the master clock

package afs_pkg;

	// clock
	localparam int CLK_PERIOD_NS   = 10;        // core clock period in ns
	localparam int SCK_MAX_MHZ     = 20;        // fastest serial clock the host may use
	localparam int SCK_MIN_PERIOD_CYC = (1000 / SCK_MAX_MHZ) / CLK_PERIOD_NS; // shortest-period floor in core cycles

	// pin synchroniser
	localparam int SYNC_STAGES     = 3;         // flip-flops per asynchronous pin
	localparam int PIN_CS          = 0;         // index of chip select
	localparam int PIN_SCK         = 1;         // index of serial clock
	localparam int PIN_SDI         = 2;         // index of serial data in
	localparam int NUM_PINS        = 3;

	// command word
	localparam int CMD_BITS        = 8;         // bits in a command or data word
	localparam int CMD_READ_BIT    = 0;         // command bit that selects a read
	localparam int ADDR_W          = 7;         // address field above the read bit
	localparam int BIT_CNT_W       = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;

	// clock tree for the conversion timebase
	localparam int PRE_W           = 2;         // analog clock divider code width
	localparam int DEC_W           = 3;         // decimation ratio code width
	localparam int DM_DIV_LOG2     = 2;         // sample clock is analog clock over four
	localparam int OSR_MIN_LOG2    = 5;         // smallest decimation ratio is 32
	localparam int HALF_DM_LOG2    = 1;         // half a sample period is two analog clocks
	localparam int RDY_CNT_W       = 18;        // holds the longest output word period

	// reset values
	localparam logic SYNC_RST      = 1'b1;      // pins read as idle high during reset
	localparam logic OE_N_RST      = 1'b1;      // drivers released during reset

	// serial port states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_WRITE,
		ST_READ
	} afs_state_type;

endpackage

// ### rtl/afs_rdy_if.sv
// carrier between the serial port top and the ready strobe generator
// assumes both ends run on the core clock

`timescale 1ns/1ps

interface afs_rdy_if;
	import afs_pkg::*;

	logic             drive_sel;  // one drives idle high, zero floats idle
	logic [PRE_W-1:0] pre_code;   // analog clock divider code
	logic [DEC_W-1:0] dec_code;   // decimation ratio code
	logic             strobe_o;   // ready pin output level
	logic             strobe_oe_n; // ready pin driver enable, low drives
	logic             conv_done;  // one-cycle pulse at each conversion end

	modport ctrl (output drive_sel, output pre_code, output dec_code,
		input strobe_o, input strobe_oe_n, input conv_done);
	modport gen (input drive_sel, input pre_code, input dec_code,
		output strobe_o, output strobe_oe_n, output conv_done);
endinterface

// ### rtl/afs_rdy_gen.sv
// conversion-ready strobe generator: timebase from master clock, divider and decimation
// assumes a synchronised active-low reset and a clock enable from the top

`timescale 1ns/1ps

module afs_rdy_gen
	import afs_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// configuration and pin
	afs_rdy_if.gen    rdy
);

	typedef struct packed {
		logic [RDY_CNT_W-1:0] cnt;   // core cycles into the output word period
		logic                 out;   // registered pin level
		logic                 oe_n;  // registered driver enable
		logic                 done;  // conversion end pulse
	} afs_gen_type;

	afs_gen_type r_ff;        // registered state
	afs_gen_type nxt_r;       // next state
	logic [RDY_CNT_W-1:0] last;   // final count of a word period
	logic [RDY_CNT_W-1:0] half;   // low time, half a sample period
	logic                 pulse;  // strobe active this cycle

	// period is four times prescale times decimation ratio core cycles
	always_comb begin
		last = (RDY_CNT_W'(1) << (DM_DIV_LOG2 + OSR_MIN_LOG2 + rdy.pre_code
			+ rdy.dec_code)) - RDY_CNT_W'(1);
		half = RDY_CNT_W'(1) << (HALF_DM_LOG2 + rdy.pre_code);
	end

	// counter wraps at each conversion end; strobe low for the first half sample period
	always_comb begin
		nxt_r      = r_ff;
		nxt_r.done = 1'b0;
		// a shrunk period after a code change wraps at once rather than running long
		if (r_ff.cnt >= last) begin
			nxt_r.cnt  = '0;
			nxt_r.done = 1'b1;
		end else begin
			nxt_r.cnt = r_ff.cnt + RDY_CNT_W'(1);
		end
		// the strobe ends by itself; no host read is needed to release it
		pulse = (r_ff.cnt < half);
		if (rdy.drive_sel) begin
			nxt_r.oe_n = 1'b0;
			nxt_r.out  = ~pulse;
		end else begin
			// float when idle, drive low only during the pulse
			nxt_r.oe_n = ~pulse;
			nxt_r.out  = 1'b0;
		end
	end

	// state register; reset holds the pin released and the timebase stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff.cnt  <= '0;
			r_ff.out  <= 1'b1;
			r_ff.oe_n <= OE_N_RST;
			r_ff.done <= 1'b0;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign rdy.strobe_o    = r_ff.out;
	assign rdy.strobe_oe_n = r_ff.oe_n;
	assign rdy.conv_done   = r_ff.done;

endmodule

// ### rtl/afs_top.sv
// serial port and ready strobe of a six-channel converter front end
// assumes serial pins come from an outside master, oversampled by the core clock
// assumes the register file sits outside, reached by the address and data ports

`timescale 1ns/1ps

module afs_top
	import afs_pkg::*;
(
	// clock, reset and enable
	input  wire logic              CORE_CLK,
	input  wire logic              RESETN,
	input  wire logic              CE,
	// serial pins from the host
	input  wire logic              CS_N,
	input  wire logic              SCK,
	input  wire logic              SDI,
	output logic                   SDO_O,
	output logic                   SDO_OE_N,
	// register access toward the register file
	output logic [ADDR_W-1:0]      RD_ADDR,
	input  wire logic [CMD_BITS-1:0] RD_DATA,
	output logic [ADDR_W-1:0]      WR_ADDR,
	output logic [CMD_BITS-1:0]    WR_DATA,
	output logic                   WR_STROBE,
	output logic                   PORT_BUSY,
	// configuration bits
	input  wire logic              READY_PIN_DRIVE_SELECT,
	input  wire logic              EXTERNAL_CLOCK_SELECT,
	input  wire logic              EXTERNAL_REFERENCE_SELECT,
	input  wire logic [PRE_W-1:0]  ANALOG_CLK_DIV_CODE,
	input  wire logic [DEC_W-1:0]  DECIMATION_RATIO_CODE,
	// clock and reference controls toward the analog side
	output logic                   CRYSTAL_OSC_EN,
	output logic                   CLK_IN_DIRECT,
	output logic                   INT_REF_EN,
	output logic                   REF_SWITCH_EN,
	// conversion ready strobe pin and status
	output logic                   CONVERSION_READY_STROBE_N_O,
	output logic                   CONVERSION_READY_STROBE_N_OE_N,
	output logic                   CONV_DONE
);

	typedef struct packed {
		logic [NUM_PINS-1:0][SYNC_STAGES-1:0] sync; // three-stage pin synchronisers
		logic [NUM_PINS-1:0] filt;       // accepted pin level, stages two and three agreed
		logic [NUM_PINS-1:0] filt_d;     // accepted level one cycle back, for edges
		afs_state_type       state;      // transaction phase
		logic [BIT_CNT_W-1:0] bit_cnt;   // bits of the current word
		logic [CMD_BITS-1:0] sh_in;      // input shift register
		logic [CMD_BITS-1:0] sh_out;     // output shift register
		logic                load_pend;  // fetch read data next cycle
		logic [ADDR_W-1:0]   addr;       // running register address
		logic [CMD_BITS-1:0] wr_data;    // last received data word
		logic                wr_stb;     // write pulse
		logic                sdo;        // output data level
		logic                sdo_oe_n;   // output driver enable
		logic                osc_en;     // crystal oscillator enable
		logic                ref_en;     // internal reference enable
	} afs_top_type;

	logic        rst_meta_ff;   // reset release first stage
	logic        rst_n_ff;      // synchronised reset used everywhere
	afs_top_type r_ff;          // registered state
	afs_top_type nxt_r;         // next state
	logic        sck_rise;      // accepted rising serial clock edge
	logic        sck_fall;      // accepted falling serial clock edge
	logic        cs_fall;       // accepted chip select falling edge
	logic        cs_high;       // chip select accepted as high
	logic [NUM_PINS-1:0] pins;  // raw pins in synchroniser order

	afs_rdy_if rdy ();          // link to the ready strobe generator

	// reset asserts at once and releases two edges later
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// configuration passes straight to the generator; it is static between changes
	assign rdy.drive_sel = READY_PIN_DRIVE_SELECT;
	assign rdy.pre_code  = ANALOG_CLK_DIV_CODE;
	assign rdy.dec_code  = DECIMATION_RATIO_CODE;

	// ready strobe runs free of the serial port
	afs_rdy_gen u_rdy_gen (
		.clk   (CORE_CLK),
		.rst_n (rst_n_ff),
		.ce    (CE),
		.rdy   (rdy.gen)
	);

	// pin vector in the order of the index constants
	always_comb begin
		pins          = '0;
		pins[PIN_CS]  = CS_N;
		pins[PIN_SCK] = SCK;
		pins[PIN_SDI] = SDI;
	end

	// edges seen only on accepted levels; serial clock is just another async pin
	always_comb begin
		sck_rise = r_ff.filt[PIN_SCK] & ~r_ff.filt_d[PIN_SCK];
		sck_fall = ~r_ff.filt[PIN_SCK] & r_ff.filt_d[PIN_SCK];
		cs_fall  = ~r_ff.filt[PIN_CS] & r_ff.filt_d[PIN_CS];
		cs_high  = r_ff.filt[PIN_CS];
	end

	// next state: synchronisers, transaction sequencer and static controls
	always_comb begin
		nxt_r        = r_ff;
		nxt_r.wr_stb = 1'b0;
		// first stage feeds only the second; acceptance compares stages two and three
		for (int i = 0; i < NUM_PINS; i++) begin
			nxt_r.sync[i] = {r_ff.sync[i][SYNC_STAGES-2:0], pins[i]};
			if (r_ff.sync[i][1] == r_ff.sync[i][2]) begin
				nxt_r.filt[i] = r_ff.sync[i][2];
			end
		end
		nxt_r.filt_d = r_ff.filt;
		// analog controls follow their select bits
		nxt_r.osc_en = ~EXTERNAL_CLOCK_SELECT;
		nxt_r.ref_en = ~EXTERNAL_REFERENCE_SELECT;

		if (cs_high) begin
			// deselected: drop the transaction, float the output, decode nothing
			nxt_r.state     = ST_IDLE;
			nxt_r.sdo_oe_n  = 1'b1;
			nxt_r.load_pend = 1'b0;
			nxt_r.bit_cnt   = '0;
		end else begin
			unique case (r_ff.state)
				ST_IDLE: begin
					// select low without a seen falling edge is not a frame
					if (cs_fall) begin
						nxt_r.state   = ST_CMD;
						nxt_r.bit_cnt = '0;
					end
				end
				ST_CMD: begin
					// command byte: output floats, mode 1,1 leading fall is ignored
					nxt_r.sdo_oe_n = 1'b1;
					if (sck_rise) begin
						nxt_r.sh_in   = {r_ff.sh_in[CMD_BITS-2:0], r_ff.filt[PIN_SDI]};
						nxt_r.bit_cnt = r_ff.bit_cnt + BIT_CNT_W'(1);
						if (r_ff.bit_cnt == BIT_LAST) begin
							// eighth bit completes the command word
							nxt_r.addr = r_ff.sh_in[CMD_BITS-2:CMD_BITS-1-ADDR_W];
							if (r_ff.filt[PIN_SDI] == 1'b1 && CMD_READ_BIT == 0) begin
								nxt_r.state     = ST_READ;
								nxt_r.load_pend = 1'b1;
							end else begin
								nxt_r.state = ST_WRITE;
							end
						end
					end
				end
				ST_WRITE: begin
					// write: output stays released for the whole frame
					nxt_r.sdo_oe_n = 1'b1;
					if (sck_rise) begin
						nxt_r.sh_in   = {r_ff.sh_in[CMD_BITS-2:0], r_ff.filt[PIN_SDI]};
						nxt_r.bit_cnt = r_ff.bit_cnt + BIT_CNT_W'(1);
						if (r_ff.bit_cnt == BIT_LAST) begin
							nxt_r.wr_data = {r_ff.sh_in[CMD_BITS-2:0], r_ff.filt[PIN_SDI]};
							nxt_r.wr_stb  = 1'b1;
							// the address moved on only after the strobe leaves
						end
					end
					if (r_ff.wr_stb) begin
						nxt_r.addr = r_ff.addr + ADDR_W'(1);
					end
				end
				ST_READ: begin
					// read: input pin is no longer looked at
					if (r_ff.load_pend) begin
						nxt_r.sh_out    = RD_DATA;
						nxt_r.load_pend = 1'b0;
					end
					if (sck_fall) begin
						// new bit goes out on each falling edge, msb first
						nxt_r.sdo      = r_ff.sh_out[CMD_BITS-1];
						nxt_r.sdo_oe_n = 1'b0;
						nxt_r.sh_out   = {r_ff.sh_out[CMD_BITS-2:0], 1'b0};
						nxt_r.bit_cnt  = r_ff.bit_cnt + BIT_CNT_W'(1);
						if (r_ff.bit_cnt == BIT_LAST) begin
							// streaming read moves to the next address
							nxt_r.addr      = r_ff.addr + ADDR_W'(1);
							nxt_r.load_pend = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// state register; hard reset idles the port, sets pins idle high and both analog enables on, and releases every driver
	always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			r_ff.sync      <= {(NUM_PINS*SYNC_STAGES){SYNC_RST}};
			r_ff.filt      <= {NUM_PINS{SYNC_RST}};
			r_ff.filt_d    <= {NUM_PINS{SYNC_RST}};
			r_ff.state     <= ST_IDLE;
			r_ff.bit_cnt   <= '0;
			r_ff.sh_in     <= '0;
			r_ff.sh_out    <= '0;
			r_ff.load_pend <= 1'b0;
			r_ff.addr      <= '0;
			r_ff.wr_data   <= '0;
			r_ff.wr_stb    <= 1'b0;
			r_ff.sdo       <= 1'b0;
			r_ff.sdo_oe_n  <= OE_N_RST;
			r_ff.osc_en    <= 1'b1;
			r_ff.ref_en    <= 1'b1;
		end else if (CE) begin
			r_ff <= nxt_r;
		end
	end

	// outputs
	assign SDO_O                          = r_ff.sdo;
	assign SDO_OE_N                       = r_ff.sdo_oe_n;
	assign RD_ADDR                        = r_ff.addr;
	assign WR_ADDR                        = r_ff.addr;
	assign WR_DATA                        = r_ff.wr_data;
	assign WR_STROBE                      = r_ff.wr_stb;
	assign PORT_BUSY                      = (r_ff.state != ST_IDLE);
	assign CRYSTAL_OSC_EN                 = r_ff.osc_en;
	assign CLK_IN_DIRECT                  = ~r_ff.osc_en;
	assign INT_REF_EN                     = r_ff.ref_en;
	assign REF_SWITCH_EN                  = r_ff.ref_en;
	assign CONVERSION_READY_STROBE_N_O    = rdy.strobe_o;
	assign CONVERSION_READY_STROBE_N_OE_N = rdy.strobe_oe_n;
	assign CONV_DONE                      = rdy.conv_done;

endmodule

// ### bench/afs_chk.sv
// concurrent checks on the ports of the serial port and ready strobe top
// assumes one core clock domain and the asynchronous active-low hard reset

`timescale 1ns/1ps

module afs_chk
	import afs_pkg::*;
(
	// clock and reset
	input wire logic             CORE_CLK,
	input wire logic             RESETN,
	input wire logic             CE,
	// serial port
	input wire logic             CS_N,
	input wire logic             SDO_OE_N,
	input wire logic             WR_STROBE,
	input wire logic             PORT_BUSY,
	// configuration
	input wire logic             READY_PIN_DRIVE_SELECT,
	input wire logic             EXTERNAL_CLOCK_SELECT,
	input wire logic             EXTERNAL_REFERENCE_SELECT,
	input wire logic [PRE_W-1:0] ANALOG_CLK_DIV_CODE,
	// analog side controls and ready pin
	input wire logic             CRYSTAL_OSC_EN,
	input wire logic             CLK_IN_DIRECT,
	input wire logic             INT_REF_EN,
	input wire logic             REF_SWITCH_EN,
	input wire logic             CONVERSION_READY_STROBE_N_O,
	input wire logic             CONVERSION_READY_STROBE_N_OE_N,
	input wire logic             CONV_DONE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	logic [3:0] up_ff;    // cycles since release, saturating
	logic [3:0] cs_hi_ff; // cycles with chip select high, saturating
	logic       up;       // internal reset surely lifted
	logic       rdy_low;  // ready pin actively pulled low

	assign up = (up_ff >= 4'h4);
	assign rdy_low = !CONVERSION_READY_STROBE_N_OE_N && !CONVERSION_READY_STROBE_N_O;

	// counters; the release waits out the two-flop reset copy inside the top
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			up_ff <= 4'h0;
			cs_hi_ff <= 4'h0;
		end else begin
			up_ff <= (up_ff == 4'hf) ? up_ff : up_ff + 4'h1;
			cs_hi_ff <= !CS_N ? 4'h0 : ((cs_hi_ff == 4'hf) ? cs_hi_ff : cs_hi_ff + 4'h1);
		end
	end

	busy_when_idle_a: assert property (cs_hi_ff == 4'hf |-> !PORT_BUSY && SDO_OE_N && !WR_STROBE)
		else $error("port active while deselected");
	write_keeps_float_a: assert property (WR_STROBE |-> SDO_OE_N)
		else $error("serial output driven in a write");
	write_one_pulse_a: assert property (WR_STROBE |=> !WR_STROBE)
		else $error("write strobe longer than one cycle");
	drive_idle_high_a: assert property (up && READY_PIN_DRIVE_SELECT && $past(READY_PIN_DRIVE_SELECT)
		|-> !CONVERSION_READY_STROBE_N_OE_N)
		else $error("ready pin not driven in drive mode");
	float_pulse_only_a: assert property (!READY_PIN_DRIVE_SELECT && !$past(READY_PIN_DRIVE_SELECT)
		&& !CONVERSION_READY_STROBE_N_OE_N |-> !CONVERSION_READY_STROBE_N_O)
		else $error("ready driver on outside pulse in float mode");
	pulse_width_a: assert property (up && $rose(rdy_low) && ANALOG_CLK_DIV_CODE == 2'h0
		|=> rdy_low ##1 (!rdy_low || ANALOG_CLK_DIV_CODE != 2'h0))
		else $error("ready pulse width wrong");
	done_then_low_a: assert property (up && CONV_DONE |-> ##[0:2] rdy_low)
		else $error("no ready pulse after conversion end");
	done_one_pulse_a: assert property (CONV_DONE |=> !CONV_DONE)
		else $error("conversion end longer than one cycle");
	xtal_follow_a: assert property (up && $past(CE) |-> CRYSTAL_OSC_EN == !$past(EXTERNAL_CLOCK_SELECT)
		&& CLK_IN_DIRECT == !CRYSTAL_OSC_EN)
		else $error("oscillator enable wrong");
	ref_follow_a: assert property (up && $past(CE) |-> INT_REF_EN == !$past(EXTERNAL_REFERENCE_SELECT)
		&& REF_SWITCH_EN == INT_REF_EN)
		else $error("reference enable wrong");
endmodule

bind afs_top afs_chk i_chk (.CORE_CLK, .RESETN, .CE, .CS_N, .SDO_OE_N, .WR_STROBE, .PORT_BUSY,
	.READY_PIN_DRIVE_SELECT, .EXTERNAL_CLOCK_SELECT, .EXTERNAL_REFERENCE_SELECT,
	.ANALOG_CLK_DIV_CODE, .CRYSTAL_OSC_EN, .CLK_IN_DIRECT, .INT_REF_EN, .REF_SWITCH_EN,
	.CONVERSION_READY_STROBE_N_O, .CONVERSION_READY_STROBE_N_OE_N, .CONV_DONE);

// ### bench/afs_host.sv
// host model: serial master driving chip select, serial clock and data in
// assumes the core clock paces it; pins move only on its falling edges

`timescale 1ns/1ps

module afs_host (
	// pacing clock
	input wire logic clk,
	// serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      sdi,
	input wire logic  sdo_o,
	input wire logic  sdo_oe_n
);
	logic sdo_last; // last driven level; a released line shows its inverse
	wire  sdo_pin = sdo_oe_n ? ~sdo_last : sdo_o;

	// idle pins at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b1;
		sdo_last = 1'b0;
	end

	// remember the driven output so a float never reads as a clean value
	always @(posedge clk) begin
		if (!sdo_oe_n) sdo_last <= sdo_o;
	end

	// phases of eight core cycles keep the serial clock far below 20 MHz
	task automatic pause(input int n);
		repeat (n) @(negedge clk);
	endtask

	// select with the clock parked at the idle level of the mode
	task automatic open_frame(input logic mode);
		sck = mode;
		pause(8);
		cs_n = 1'b0;
		pause(8);
	endtask

	// msb first: data set while low, taken on the rise, output read before it
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sck = 1'b0;
			sdi = tx[i];
			pause(8);
			rx[i] = sdo_pin;
			sck = 1'b1;
			pause(8);
		end
	endtask

	// park the clock, then deselect to end the frame
	task automatic close_frame(input logic mode);
		sck = mode;
		pause(8);
		cs_n = 1'b1;
		pause(12);
	endtask
endmodule

// ### bench/afs_top_tb.sv
// self-checking bench for the serial port and ready strobe top
// assumes the host model drives the serial pins and the bench plays the register file

`timescale 1ns/1ps

module afs_top_tb;
	import afs_pkg::*;

	logic                CORE_CLK, RESETN, CE, CS_N, SCK, SDI, SDO_O, SDO_OE_N, WR_STROBE;
	logic                PORT_BUSY, READY_PIN_DRIVE_SELECT, EXTERNAL_CLOCK_SELECT, CONV_DONE;
	logic                EXTERNAL_REFERENCE_SELECT, CRYSTAL_OSC_EN, CLK_IN_DIRECT, INT_REF_EN;
	logic                REF_SWITCH_EN, CONVERSION_READY_STROBE_N_O, CONVERSION_READY_STROBE_N_OE_N;
	logic [PRE_W-1:0]    ANALOG_CLK_DIV_CODE;
	logic [DEC_W-1:0]    DECIMATION_RATIO_CODE;
	logic [ADDR_W-1:0]   RD_ADDR, WR_ADDR, wr_a;
	logic [CMD_BITS-1:0] RD_DATA, WR_DATA, wr_d, rx;
	logic                drv;
	int                  failures, samples_checked, wr_cnt, n, lo, per;

	// register file contents: a fixed scramble of the address
	function automatic logic [7:0] rd_exp(input logic [6:0] a);
		return {a[3:0], ~a[6:3]};
	endfunction
	assign RD_DATA = rd_exp(RD_ADDR);
	// ready line carries a pull-up, so a released pin reads high
	wire rdy_pin = CONVERSION_READY_STROBE_N_OE_N ? 1'b1 : CONVERSION_READY_STROBE_N_O;

	afs_top i_dut (.CORE_CLK, .RESETN, .CE, .CS_N, .SCK, .SDI, .SDO_O, .SDO_OE_N, .RD_ADDR,
		.RD_DATA, .WR_ADDR, .WR_DATA, .WR_STROBE, .PORT_BUSY, .READY_PIN_DRIVE_SELECT,
		.EXTERNAL_CLOCK_SELECT, .EXTERNAL_REFERENCE_SELECT, .ANALOG_CLK_DIV_CODE,
		.DECIMATION_RATIO_CODE, .CRYSTAL_OSC_EN, .CLK_IN_DIRECT, .INT_REF_EN, .REF_SWITCH_EN,
		.CONVERSION_READY_STROBE_N_O, .CONVERSION_READY_STROBE_N_OE_N, .CONV_DONE);
	afs_host i_host (.clk(CORE_CLK), .cs_n(CS_N), .sck(SCK), .sdi(SDI), .sdo_o(SDO_O),
		.sdo_oe_n(SDO_OE_N));

	// 100 MHz core clock
	always #5 CORE_CLK = ~CORE_CLK;

	// capture writes and any drive of the serial output
	always @(posedge CORE_CLK) begin
		if (WR_STROBE) begin
			wr_cnt <= wr_cnt + 1;
			wr_a <= WR_ADDR;
			wr_d <= WR_DATA;
		end
		if (!SDO_OE_N) drv <= 1'b1;
	end

	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// counts, verdict, end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// skip a pulse in progress, then time one low part and the spacing to the next
	task automatic pulse(output int lo, output int per);
		int k;
		lo = 0;
		k = 0;
		while (rdy_pin === 1'b0 && k < 5000) begin @(negedge CORE_CLK); k++; end
		while (rdy_pin !== 1'b0 && k < 5000) begin @(negedge CORE_CLK); k++; end
		while (rdy_pin === 1'b0 && k < 5000) begin @(negedge CORE_CLK); k++; lo++; end
		per = lo;
		while (rdy_pin !== 1'b0 && k < 5000) begin @(negedge CORE_CLK); k++; per++; end
		if (k >= 5000) begin
			failures++;
			wrap_up();
		end
	endtask

	initial begin
		{CORE_CLK, RESETN, READY_PIN_DRIVE_SELECT, EXTERNAL_CLOCK_SELECT} = 4'h0;
		{CE, EXTERNAL_REFERENCE_SELECT, ANALOG_CLK_DIV_CODE, DECIMATION_RATIO_CODE} = 7'h40;
		{failures, samples_checked, wr_cnt, drv} = '0;
		repeat (10) @(negedge CORE_CLK);
		RESETN = 1'b1;
		repeat (8) @(negedge CORE_CLK);
		check("osc_en", {CRYSTAL_OSC_EN, CLK_IN_DIRECT}, 2'h2);
		check("ref_en", {INT_REF_EN, REF_SWITCH_EN}, 2'h3);
		{EXTERNAL_CLOCK_SELECT, EXTERNAL_REFERENCE_SELECT} = 2'h3;
		repeat (3) @(negedge CORE_CLK);
		check("osc_ext", {CRYSTAL_OSC_EN, CLK_IN_DIRECT, INT_REF_EN, REF_SWITCH_EN}, 4'h4);
		// write then two-byte read, in each serial mode
		for (int m = 0; m < 2; m++) begin
			drv = 1'b0;
			n = wr_cnt;
			i_host.open_frame(m[0]);
			i_host.xfer(8'h24 | 8'(m << 1), 8, rx);
			i_host.xfer(8'hc3 ^ 8'(m), 8, rx);
			i_host.close_frame(m[0]);
			check("wr_count", wr_cnt, n + 1);
			check("wr_addr", wr_a, 7'h12 | 7'(m));
			check("wr_data", wr_d, 8'hc3 ^ 8'(m));
			check("wr_float", drv, 1'h0);
			i_host.open_frame(m[0]);
			i_host.xfer(8'h81 | 8'(m << 1), 8, rx);
			check("cmd_float", drv, 1'h0);
			i_host.xfer(8'ha5, 8, rx);
			check("rd_byte0", rx, rd_exp(7'h40 | 7'(m)));
			i_host.xfer(8'h5a, 8, rx);
			check("rd_byte1", rx, rd_exp(7'h41 + 7'(m)));
			i_host.close_frame(m[0]);
			check("rd_release", {drv, SDO_OE_N, 8'(wr_cnt)}, {2'h3, 8'(n + 1)});
		end
		// a partial byte at deselect is dropped
		i_host.open_frame(1'b0);
		i_host.xfer(8'h30, 8, rx);
		i_host.xfer(8'hff, 4, rx);
		i_host.close_frame(1'b0);
		check("partial", wr_cnt, n + 1);
		// clock and data toggling while deselected
		i_host.xfer(8'h30, 8, rx);
		i_host.close_frame(1'b0);
		check("deselected", {PORT_BUSY, 8'(wr_cnt)}, {1'h0, 8'(n + 1)});
		// a full write frame under hard reset
		RESETN = 1'b0;
		i_host.open_frame(1'b0);
		i_host.xfer(8'h30, 8, rx);
		i_host.xfer(8'h11, 8, rx);
		check("rst_block", {SDO_OE_N, PORT_BUSY, 8'(wr_cnt)}, {2'h2, 8'(n + 1)});
		check("rst_osc", {CRYSTAL_OSC_EN, INT_REF_EN}, 2'h3);
		i_host.close_frame(1'b0);
		RESETN = 1'b1;
		repeat (8) @(negedge CORE_CLK);
		// ready strobe over every divider code and a second ratio, both drive modes
		for (int i = 0; i < 5; i++) begin
			ANALOG_CLK_DIV_CODE = i[1:0];
			DECIMATION_RATIO_CODE = 3'(i / 4);
			READY_PIN_DRIVE_SELECT = i[0];
			pulse(lo, per);
			pulse(lo, per);
			check("rdy_low", lo, 2 << i[1:0]);
			check("rdy_period", per, (128 << i[1:0]) << (i / 4));
			repeat (20) @(negedge CORE_CLK);
			check("rdy_idle_oe", CONVERSION_READY_STROBE_N_OE_N, !i[0]);
		end
		// freeze the timebase for 200 cycles while the pin idles; the next pulse slips by that much
		CE = 1'b0;
		repeat (200) @(negedge CORE_CLK);
		CE = 1'b1;
		n = 0;
		while (rdy_pin !== 1'b0 && n < 5000) begin @(negedge CORE_CLK); n++; end
		check("ce_freeze", n, (128 << 1) - 20);
		wrap_up();
	end
endmodule
